// *** logic/aich_top.sv ***
// adapter side of the confirmation and initialization exchange
// assumes avalon-mm master on mclk_in, byte link with ready on tx
`timescale 1ns/1ps
`include "aich_map.svh"
module aich_top import aich_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [8:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic net_enable_out,
  output logic inquiry_req_out,
  output logic status_req_out
);
  // received frame from the parser
  aich_frame_type fr;
  logic fr_ok;

  aich_rx_parser u_rx (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in),
    .frame_out(fr),
    .frame_ok_out(fr_ok)
  );

  // software visible state
  logic [31:0] cfg_r; // type, speed, retry limit, timeout
  logic [7:0] swid_r; // lower-layer software id
  logic [3:0] idlen_r; // identifier length in bytes
  logic [63:0] uid_r; // unique number
  logic [1:0] objcnt_r; // objects held
  logic [7:0] obj_mem [0:53]; // maintenance object bytes
  logic [15:0] err_r; // error stop cause
  logic [15:0] meth_r; // last init method
  logic [15:0] cres_r; // last confirm result
  logic ack_seen_r; // notification acceptance seen
  logic [15:0] ack_res_r; // its result
  // adapter control
  aich_state_type st_r, st_nxt;
  logic [3:0] fails_r, fails_nxt;
  logic wait_r, wait_nxt; // confirm request outstanding
  logic [23:0] tmo_r; // confirm timeout countdown
  logic done_pend_r, done_pend_nxt; // notification owed
  logic done_bad_r, done_bad_nxt; // init ended abnormally
  logic [15:0] cause_r, cause_nxt; // cause held until error stop
  logic [7:0] own_fn_r; // function number of our requests
  // transmit engine
  aich_tx_kind_type kind_r, kind_nxt;
  logic [15:0] res_r, res_nxt; // result placed in responses
  logic [7:0] fn_r, fn_nxt; // function number placed in frame
  logic [6:0] tidx_r; // index of next byte to load
  logic [7:0] tsum_r; // check sum of sent bytes
  logic tx_start;
  // bus slave
  wire wreq_r = avs_waitrequest_out; // request not yet acknowledged
  logic [31:0] rd_mux;

  // ---- bus decode ----
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_wr = avs_write_in & ~wreq_r; // takes effect on ack edge
  wire [8:0] a = avs_address_in;
  wire hit_obj = a[8] & (a[7:2] < `AICH_OBJ_BYTES);
  wire [5:0] obj_ix = a[7:2];
  wire wr_ctrl = bus_wr & (a == `AICH_REG_CTRL);
  wire c_restart = wr_ctrl & avs_writedata_in[0];
  wire c_init_ok = wr_ctrl & avs_writedata_in[1];
  wire c_init_fail = wr_ctrl & avs_writedata_in[2];
  wire c_op_fail = wr_ctrl & avs_writedata_in[3];
  wire c_obj_fail = wr_ctrl & avs_writedata_in[4];

  // ---- config fields ----
  wire [7:0] ad_type = cfg_r[7:0];
  wire [7:0] speed = {5'h00, cfg_r[10:8]};
  wire [3:0] retry_lim = cfg_r[15:12];
  wire [23:0] tmo_load = {cfg_r[31:16], 8'h00};

  // ---- received frame classes ----
  wire f_conf = fr_ok & (fr.frame_type == `AICH_FT_CONF);
  wire f_init = fr_ok & (fr.frame_type == `AICH_FT_INIT);
  wire is_conf_rsp = f_conf & (fr.command_code == `AICH_CN_CONF_RSP);
  // own_fn_r moves on at launch, so the outstanding number is one back
  wire fn_match = (fr.function_number == own_fn_r - 8'h01) |
                  (fr.function_number == 8'h00);
  wire is_init_req = f_init & (fr.command_code == `AICH_CN_INIT_REQ);
  wire is_done_ack = f_init & (fr.command_code == `AICH_CN_DONE_ACK);
  wire [15:0] meth = fr.payload_field;
  wire meth_ok = (meth >= `AICH_METH_MIN) &
                 (meth <= `AICH_METH_MAX);
  wire meth_discard = ~meth[0];
  wire tx_idle = ~tx_valid_out;
  wire tmo_hit = wait_r & (tmo_r == 24'h000000);
  wire [3:0] fails_inc = fails_r + 4'h1;

  // ---- frame assembly ----
  logic [15:0] t_ft; // frame type of frame in flight
  logic [7:0] t_cn; // command code
  logic [15:0] t_dl; // payload length
  logic [7:0] t_obj_len; // object area size
  always_comb begin
    case (objcnt_r)
      2'h0: t_obj_len = 8'h00;
      2'h1: t_obj_len = 8'h13;
      2'h2: t_obj_len = 8'h25;
      default: t_obj_len = 8'h37;
    endcase
  end
  always_comb begin
    case (kind_r)
      TX_CONF: begin
        t_ft = `AICH_FT_CONF;
        t_cn = `AICH_CN_CONF_REQ;
        t_dl = {8'h00, t_obj_len} + 16'h0002;
      end
      TX_INIT: begin
        t_ft = `AICH_FT_INIT;
        t_cn = `AICH_CN_INIT_RSP;
        t_dl = (res_r == `AICH_RES_OK) ? `AICH_DL_LONG
                                       : `AICH_DL_SHORT;
      end
      default: begin
        t_ft = `AICH_FT_INIT;
        t_cn = `AICH_CN_DONE_NTF;
        t_dl = `AICH_DL_SHORT;
      end
    endcase
  end

  wire [6:0] t_last = `AICH_HDR_LEN + t_dl[6:0]; // index of check byte
  wire [6:0] q = tidx_r - `AICH_HDR_LEN; // payload index
  wire [5:0] oq = q[5:0] - 6'h03; // object byte index
  wire [2:0] uq = q[2:0] - 3'h3; // unique number byte index
  wire uid_ok = (idlen_r <= `AICH_UID_BYTES);
  logic [7:0] uid_b;
  logic [7:0] t_byte; // next byte to load
  always_comb begin
    uid_b = uid_r[8'(7 - uq) * 8 +: 8];
    if (!uid_ok) begin
      uid_b = 8'h00;
    end
  end
  // byte at tidx_r of the frame in flight
  always_comb begin
    t_byte = 8'h00;
    case (tidx_r)
      7'h00: t_byte = `AICH_STX;
      7'h01: t_byte = t_ft[15:8];
      7'h02: t_byte = t_ft[7:0];
      7'h03: t_byte = t_cn;
      7'h04: t_byte = fn_r;
      7'h05: t_byte = t_dl[15:8];
      7'h06: t_byte = t_dl[7:0];
      default: begin
        if (kind_r == TX_CONF) begin
          if (q == 7'h00) t_byte = ad_type;
          else if (q == 7'h01) t_byte = speed;
          else if (q == 7'h02) t_byte = {6'h00, objcnt_r};
          else t_byte = obj_mem[oq];
        end else begin
          if (q == 7'h00) t_byte = res_r[15:8];
          else if (q == 7'h01) t_byte = res_r[7:0];
          else if (q == 7'h02) t_byte = swid_r;
          else t_byte = uid_b;
        end
      end
    endcase
  end

  // ---- adapter state machine, next values ----
  always_comb begin
    st_nxt = st_r;
    fails_nxt = fails_r;
    wait_nxt = wait_r;
    done_pend_nxt = done_pend_r;
    done_bad_nxt = done_bad_r;
    cause_nxt = cause_r;
    kind_nxt = kind_r;
    res_nxt = res_r;
    fn_nxt = fn_r;
    tx_start = 1'b0;
    // init request answered wherever it may be taken
    if (is_init_req && tx_idle &&
        (st_r != ST_CONSTRUCT)) begin
      tx_start = 1'b1;
      kind_nxt = TX_INIT;
      fn_nxt = fr.function_number;
      if (st_r == ST_CONFIRM || st_r == ST_UNRECOG) begin
        res_nxt = `AICH_RES_UNCONF;
      end else if (!meth_ok) begin
        res_nxt = `AICH_RES_REJECT;
      end else begin
        res_nxt = `AICH_RES_OK;
        st_nxt = ST_CONSTRUCT;
        done_pend_nxt = 1'b0;
      end
    end
    case (st_r)
      ST_CONFIRM: begin
        // only confirm responses count here
        if (!wait_r && tx_idle && !tx_start) begin
          tx_start = 1'b1;
          kind_nxt = TX_CONF;
          fn_nxt = own_fn_r;
          wait_nxt = 1'b1;
        end else if (wait_r && is_conf_rsp && fn_match &&
                     fr.payload_field == `AICH_RES_OK) begin
          wait_nxt = 1'b0;
          fails_nxt = 4'h0;
          st_nxt = ST_STANDBY;
        end else if (wait_r && (tmo_hit ||
                     (is_conf_rsp && fn_match))) begin
          wait_nxt = 1'b0;
          fails_nxt = fails_inc;
          if (fails_inc >= retry_lim) begin
            st_nxt = ST_UNRECOG;
          end
        end
      end
      ST_CONSTRUCT: begin
        // software reports how construction ended
        if (c_init_ok) begin
          done_pend_nxt = 1'b1;
          done_bad_nxt = 1'b0;
        end else if (c_init_fail || c_obj_fail) begin
          done_pend_nxt = 1'b1;
          done_bad_nxt = 1'b1;
          cause_nxt = c_obj_fail ? `AICH_ERR_OBJ
                                 : `AICH_ERR_INIT;
        end
        if (done_pend_r && tx_idle) begin
          tx_start = 1'b1;
          kind_nxt = TX_DONE;
          fn_nxt = own_fn_r;
          res_nxt = done_bad_r ? `AICH_RES_REJECT
                               : `AICH_RES_OK;
          done_pend_nxt = 1'b0;
          st_nxt = done_bad_r ? ST_ERROR : ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (c_op_fail && st_nxt == ST_NORMAL) begin
          cause_nxt = `AICH_ERR_OPER;
          st_nxt = ST_ERROR;
        end
      end
      default: ;
    endcase
    // restart of confirmation overrides state, retry count, wait and pending notification
    if (c_restart) begin
      st_nxt = ST_CONFIRM;
      fails_nxt = 4'h0;
      wait_nxt = 1'b0;
      done_pend_nxt = 1'b0;
    end
  end

  // ---- adapter state registers ----
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= ST_CONFIRM;
      fails_r <= 4'h0;
      wait_r <= 1'b0;
      done_pend_r <= 1'b0;
      done_bad_r <= 1'b0;
      cause_r <= 16'h0000;
      kind_r <= TX_CONF;
      res_r <= 16'h0000;
      fn_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      fails_r <= fails_nxt;
      wait_r <= wait_nxt;
      done_pend_r <= done_pend_nxt;
      done_bad_r <= done_bad_nxt;
      cause_r <= cause_nxt;
      kind_r <= kind_nxt;
      res_r <= res_nxt;
      fn_r <= fn_nxt;
    end
  end

  // ---- side effects of transitions ----
  // pulses rise on the transition edge itself, together with the new state
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      net_enable_out <= 1'b0;
      status_req_out <= 1'b0;
      inquiry_req_out <= 1'b0;
      err_r <= 16'h0000;
      own_fn_r <= 8'h01;
      tmo_r <= 24'h000000;
      cres_r <= 16'h0000;
      meth_r <= 16'h0000;
      ack_seen_r <= 1'b0;
      ack_res_r <= 16'h0000;
    end else begin
      net_enable_out <= (st_nxt == ST_NORMAL);
      status_req_out <= (st_nxt == ST_NORMAL) &&
                        (st_r != ST_NORMAL);
      inquiry_req_out <= (st_nxt == ST_CONSTRUCT) &&
                         (st_r != ST_CONSTRUCT) &&
                         !meth_discard && (objcnt_r == 2'h0);
      if (st_nxt == ST_ERROR && st_r != ST_ERROR) begin
        err_r <= cause_nxt;
      end
      if (tx_start && kind_nxt == TX_CONF) begin
        tmo_r <= tmo_load;
      end else if (wait_r && tmo_r != 24'h000000) begin
        tmo_r <= tmo_r - 24'h000001;
      end
      if (tx_start && kind_nxt != TX_INIT) begin
        own_fn_r <= own_fn_r + 8'h01;
      end
      if (is_conf_rsp) begin
        cres_r <= fr.payload_field;
      end
      if (is_init_req) begin
        meth_r <= meth;
      end
      // acceptance seen; new ack wins over clear
      if (is_done_ack) begin
        ack_seen_r <= 1'b1;
        ack_res_r <= fr.payload_field;
      end else if (c_restart) begin
        ack_seen_r <= 1'b0;
      end
    end
  end

  // ---- transmit engine ----
  // one byte per accepted handshake, check byte appended last
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tidx_r <= 7'h00;
      tsum_r <= 8'h00;
    end else if (tx_start) begin
      tx_valid_out <= 1'b1;
      tx_data_out <= `AICH_STX;
      tidx_r <= 7'h01;
      tsum_r <= 8'h00;
    end else if (tx_valid_out && tx_ready_in) begin
      if (tidx_r > t_last) begin
        tx_valid_out <= 1'b0;
      end else if (tidx_r == t_last) begin
        tx_data_out <= (tidx_r == 7'h01) ? 8'h00
                       : tsum_r + tx_data_out;
        tidx_r <= tidx_r + 7'h01;
      end else begin
        tx_data_out <= t_byte;
        tsum_r <= (tidx_r == 7'h01) ? 8'h00
                  : tsum_r + tx_data_out;
        tidx_r <= tidx_r + 7'h01;
      end
    end
  end

  // ---- object area and configuration writes ----
  // discard method empties the object table
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_r <= `AICH_CFG_RST;
      swid_r <= 8'h00;
      idlen_r <= 4'h0;
      uid_r <= 64'h0;
      objcnt_r <= 2'h0;
    end else begin
      if (bus_wr && a == `AICH_REG_CFG) cfg_r <= avs_writedata_in;
      if (bus_wr && a == `AICH_REG_NODE) begin
        swid_r <= avs_writedata_in[7:0];
        idlen_r <= avs_writedata_in[11:8];
      end
      if (bus_wr && a == `AICH_REG_UID_LO)
        uid_r[31:0] <= avs_writedata_in;
      if (bus_wr && a == `AICH_REG_UID_HI)
        uid_r[63:32] <= avs_writedata_in;
      if (is_init_req && st_nxt == ST_CONSTRUCT &&
          st_r != ST_CONSTRUCT && meth_discard) begin
        objcnt_r <= 2'h0;
      end else if (bus_wr && a == `AICH_REG_OBJCNT) begin
        objcnt_r <= avs_writedata_in[1:0];
      end
    end
  end

  // object bytes need no reset; count governs what is sent
  always_ff @(posedge mclk_in) begin
    if (bus_wr && hit_obj) obj_mem[obj_ix] <= avs_writedata_in[7:0];
  end

  // ---- bus answer ----
  always_comb begin
    case (a)
      `AICH_REG_CFG: rd_mux = cfg_r;
      `AICH_REG_STATUS:
        rd_mux = {cres_r, 3'h0, ack_seen_r, fails_r, 5'h00, st_r};
      `AICH_REG_ERR: rd_mux = {meth_r, err_r};
      `AICH_REG_NODE: rd_mux = {20'h0, idlen_r, swid_r};
      `AICH_REG_UID_LO: rd_mux = uid_r[31:0];
      `AICH_REG_UID_HI: rd_mux = uid_r[63:32];
      `AICH_REG_OBJCNT: rd_mux = {ack_res_r, 14'h0, objcnt_r};
      default: rd_mux = hit_obj ? {24'h0, obj_mem[obj_ix]} : 32'h0;
    endcase
  end

  // one wait cycle per access; data stands in the ack cycle
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) avs_readdata_out <= rd_mux;
    end
  end
endmodule // aich_top

// *** shared/aich_map.svh ***
// constants of the adapter init command handler: framing, codes, registers
// assumes byte frames, 125 MHz mclk_in, avalon word offsets in bytes
//
// Summary of operation
// - normal state refuses construction frames; network only; the code answers init requests there and enters construction on methods 1-6
// - entering normal requests initial status values
// - adapter sends confirm request, start 02 type 0000
// - no objects: count zero, empty object area; the code sends no count byte then, payload length 2
// - first payload byte carries adapter type
// - second payload byte carries serial speed code
// - object area: count then 18 bytes each
// - entry: class code, maker code, product code
// - init request in standby enters construction
// - method 1 keeps objects, 2 discards them
// - methods 3,5 retain; 4,6 discard; rest reserved
// - init response code 81 with result codes
// - response carries software id and unique number
// - completion notification sent on success or failure
// - notification type 0001 code 02 with result
// - confirm state discards others; retries then unrecognized
// - standby accepts only init request frames
// - error stop records its cause code
`ifndef AICH_MAP_SVH
`define AICH_MAP_SVH
`define AICH_STX 8'h02
`define AICH_FT_CONF 16'h0000
`define AICH_FT_INIT 16'h0001
`define AICH_FT_OBJ 16'h0002
`define AICH_CN_CONF_REQ 8'h00
`define AICH_CN_CONF_RSP 8'h80
`define AICH_CN_INIT_REQ 8'h01
`define AICH_CN_INIT_RSP 8'h81
`define AICH_CN_DONE_NTF 8'h02
`define AICH_CN_DONE_ACK 8'h82
`define AICH_RES_OK 16'h0000
`define AICH_RES_REJECT 16'h0011
`define AICH_RES_UNCONF 16'h0101
`define AICH_DL_SHORT 16'h0002
`define AICH_DL_LONG 16'h000b
`define AICH_METH_MIN 16'h0001
`define AICH_METH_MAX 16'h0006
`define AICH_ERR_OBJ 16'h03ea
`define AICH_ERR_INIT 16'h03eb
`define AICH_ERR_OPER 16'h03ec
`define AICH_OBJ_BYTES 6'h36
`define AICH_UID_BYTES 4'h8
`define AICH_HDR_LEN 7'h07
`define AICH_REG_CTRL 9'h000
`define AICH_REG_CFG 9'h004
`define AICH_REG_STATUS 9'h008
`define AICH_REG_ERR 9'h00c
`define AICH_REG_NODE 9'h010
`define AICH_REG_UID_LO 9'h014
`define AICH_REG_UID_HI 9'h018
`define AICH_REG_OBJCNT 9'h01c
`define AICH_CFG_RST 32'h00ff_3102
`define AICH_TMO_SHIFT 8
`endif

// *** shared/aich_pkg.sv ***
// types shared by the adapter init command handler modules
// assumes aich_map.svh supplies every numeric constant
package aich_pkg;
  // adapter operating states
  typedef enum logic [2:0] {
    ST_CONFIRM, ST_STANDBY, ST_CONSTRUCT, ST_NORMAL, ST_ERROR, ST_UNRECOG
  } aich_state_type;
  // receive parser states
  typedef enum logic [1:0] {
    RX_IDLE, RX_HDR, RX_PAY, RX_CHK
  } aich_rx_state_type;
  // frames the adapter can originate
  typedef enum logic [1:0] {
    TX_CONF, TX_INIT, TX_DONE
  } aich_tx_kind_type;
  // one received frame, checked
  typedef struct packed {
    logic [15:0] frame_type;
    logic [7:0] command_code;
    logic [7:0] function_number;
    logic [15:0] payload_length;
    logic [15:0] payload_field;
  } aich_frame_type;
endpackage

// *** logic/aich_rx_parser.sv ***
// byte-stream frame receiver with check byte verification
// assumes rx bytes synchronous to mclk_in, one per valid cycle
`timescale 1ns/1ps
`include "aich_map.svh"
module aich_rx_parser import aich_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output aich_frame_type frame_out,
  output logic frame_ok_out
);
  aich_rx_state_type st_r; // parser state
  logic [15:0] cnt_r; // byte count in field
  logic [7:0] sum_r; // running check sum
  logic [7:0] b; // current byte
  logic [15:0] dl_w; // length being assembled
  assign b = rx_data_in;
  assign dl_w = {frame_out.payload_length[7:0], b};

  // sum of every byte after the start byte; kept simple on purpose
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= RX_IDLE;
      cnt_r <= 16'h0000;
      sum_r <= 8'h00;
      frame_out <= '0;
      frame_ok_out <= 1'b0;
    end else begin
      frame_ok_out <= 1'b0;
      if (rx_valid_in) begin
        sum_r <= sum_r + b;
        cnt_r <= cnt_r + 16'h0001;
        case (st_r)
          RX_IDLE: begin
            // junk between frames is skipped
            if (b == `AICH_STX) begin
              st_r <= RX_HDR;
              cnt_r <= 16'h0000;
              sum_r <= 8'h00;
              frame_out.payload_field <= 16'h0000;
            end
          end
          RX_HDR: begin
            case (cnt_r[2:0])
              3'h0: frame_out.frame_type[15:8] <= b;
              3'h1: frame_out.frame_type[7:0] <= b;
              3'h2: frame_out.command_code <= b;
              3'h3: frame_out.function_number <= b;
              default: frame_out.payload_length <= dl_w;
            endcase
            if (cnt_r == 16'h0005) begin
              cnt_r <= 16'h0000;
              st_r <= (dl_w == 16'h0000) ? RX_CHK : RX_PAY;
            end
          end
          RX_PAY: begin
            // first two payload bytes kept, big end first
            if (cnt_r < 16'h0002) begin
              frame_out.payload_field <=
                {frame_out.payload_field[7:0], b};
            end
            if (cnt_r == frame_out.payload_length - 16'h0001) begin
              st_r <= RX_CHK;
            end
          end
          RX_CHK: begin
            frame_ok_out <= (b == sum_r);
            st_r <= RX_IDLE;
          end
          default: st_r <= RX_IDLE;
        endcase
      end
    end
  end
endmodule // aich_rx_parser

// *** test/aich_assertions.sv ***
// checker on aich_top ports: bus handshake, byte link, pulses
// assumes it is bound to every aich_top instance
`timescale 1ns/1ps
module aich_assertions (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic net_enable_out,
  input wire logic inquiry_req_out,
  input wire logic status_req_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  wire req = avs_read_in || avs_write_in; // any bus request
  AST_ONE_WAIT: assert property (req && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("no ack after one wait");
  AST_ACK_ONCE: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("ack held too long");
  AST_IDLE_WAIT: assert property (!req |-> avs_waitrequest_out)
    else $error("ack without request");
  AST_FRAME_START: assert property ($rose(tx_valid_out) |->
    tx_data_out == 8'h02) else $error("frame start byte wrong");
  AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("tx byte lost");
  AST_TX_DROP: assert property ($fell(tx_valid_out) |-> $past(tx_ready_in))
    else $error("tx valid fell unaccepted");
  AST_STATUS_NET: assert property (status_req_out |->
    ##[0:2] net_enable_out) else $error("status fetch outside normal");
  AST_STATUS_ONE: assert property (status_req_out |=> !status_req_out)
    else $error("status pulse too long");
  AST_INQ_BUILD: assert property (inquiry_req_out |-> !net_enable_out
    ##1 !inquiry_req_out) else $error("inquiry pulse wrong");
  cover property ($rose(net_enable_out));
  cover property (inquiry_req_out);
  cover property (tx_valid_out && !tx_ready_in);
endmodule // aich_assertions
bind aich_top aich_assertions u_aich_assertions (.mclk_in, .rstn_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .tx_ready_in,
  .tx_valid_out, .tx_data_out, .net_enable_out, .inquiry_req_out,
  .status_req_out);

// *** test/aich_equip_model.sv ***
// equipment controller model on the adapter byte link
// assumes bytes one per cycle; stalls tx at random
`timescale 1ns/1ps
module aich_equip_model (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [7:0] conf_res_in,
  input wire logic mute_in,
  output logic tx_ready_in,
  output logic rx_valid_in,
  output logic [7:0] rx_data_in
);
  logic [7:0] fr [0:63]; // last frame from the adapter
  logic [7:0] q [$]; // bytes queued toward the adapter
  int nb = 0; // bytes of the current frame
  int frames = 0; // complete frames seen
  int seed = 62988;
  initial begin
    tx_ready_in = 1'b0;
    rx_valid_in = 1'b0;
    rx_data_in = 8'h00;
  end
  // frame a payload; bad spoils the check byte
  task automatic put(input logic [7:0] b [$], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    q.push_back(8'h02);
    foreach (b[i]) begin
      q.push_back(b[i]);
      s += b[i];
    end
    q.push_back(s + 8'(bad));
  endtask
  // idle line toggles so no stale byte survives
  always @(posedge mclk_in) begin
    tx_ready_in <= 1'($random(seed));
    rx_valid_in <= q.size() > 0;
    rx_data_in <= (q.size() > 0) ? q.pop_front() : ~rx_data_in;
    if (!rstn_in) nb = 0;
    else if (tx_valid_out && tx_ready_in) begin
      fr[nb] = tx_data_out;
      nb++;
      if (nb >= 7 && nb == {fr[5], fr[6]} + 8) begin
        nb = 0;
        frames++;
        if (fr[3] == 8'h00 && !mute_in)
          put('{8'h00, 8'h00, 8'h80, fr[4], 8'h00, 8'h01, conf_res_in}, 0);
        if (fr[3] == 8'h02)
          put('{8'h00, 8'h01, 8'h82, fr[4], 8'h00, 8'h02, 8'h0, 8'h0}, 0);
      end
    end
  end
endmodule // aich_equip_model

// *** test/test_adapter_init_command_handler.sv ***
// bench for aich_top against the equipment model
// assumes the bound checker; clock 125 MHz
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
`define EQ u_aich_equip_model
module test_adapter_init_command_handler;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [8:0] avs_address_in = 9'h000;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
  logic avs_waitrequest_out, rx_valid_in, tx_ready_in, tx_valid_out;
  logic [7:0] rx_data_in, tx_data_out, conf_res = 8'h11, fn;
  logic net_enable_out, inquiry_req_out, status_req_out, mute = 1'b0;
  logic [15:0] meth;
  int error_cnt = 0, compares = 0, inq = 0, sts = 0, seed = 62988, n0;
  aich_top u_aich_top (.mclk_in, .rstn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .rx_valid_in, .rx_data_in, .tx_ready_in, .tx_valid_out, .tx_data_out,
    .net_enable_out, .inquiry_req_out, .status_req_out);
  aich_equip_model u_aich_equip_model (.mclk_in, .rstn_in, .tx_valid_out,
    .tx_data_out, .conf_res_in(conf_res), .mute_in(mute), .tx_ready_in,
    .rx_valid_in, .rx_data_in);
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (inquiry_req_out === 1'b1) inq++;
  always @(posedge mclk_in) if (status_req_out === 1'b1) sts++;
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0 && ++k < 64);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  // poll the state field until it shows s
  task automatic ws(input logic [2:0] s);
    int k;
    k = 0;
    do bus(1'b0, 9'h008, 32'h0); while (rd[2:0] !== s && ++k < 4000);
    `CHK(rd[2:0], s)
  endtask
  task automatic wf(input int n);
    int k;
    k = 0;
    while (`EQ.frames < n && ++k < 3000) @(posedge mclk_in);
    `CHK(`EQ.frames, n)
  endtask
  task automatic init(input logic [15:0] m, input logic bad);
    `EQ.put('{8'h00, 8'h01, 8'h01, 8'h5a, 8'h00, 8'h02, m[15:8], m[7:0]}, bad);
  endtask
  // command, length and first two payload bytes of the last adapter frame
  function automatic logic [39:0] hd();
    hd = {`EQ.fr[3], `EQ.fr[5], `EQ.fr[6], `EQ.fr[7], `EQ.fr[8]};
  endfunction
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_in);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    bus(1'b0, 9'h004, 32'h0);
    `CHK(rd, 32'h00ff_3102)
    bus(1'b1, 9'h004, 32'h0004_3102);
    wf(1);
    conf_res <= 8'h00;
    `CHK({`EQ.fr[0], `EQ.fr[1], `EQ.fr[2], `EQ.fr[3]}, 32'h0200_0000)
    `CHK(hd(), 40'h00_0002_0201)
    fn = `EQ.fr[4];
    ws(3'h1);
    `CHK(rd[11:8], 4'h0)
    `CHK(`EQ.fr[4], fn + 8'h01)
    init(16'h0001, 1'b1);
    repeat (40) @(posedge mclk_in);
    `CHK(`EQ.frames, 2)
    init(16'h0007, 1'b0);
    wf(3);
    `CHK(hd(), 40'h81_0002_0011)
    ws(3'h1);
    bus(1'b1, 9'h010, 32'h0000_0905);
    bus(1'b1, 9'h014, 32'hffff_ffff);
    meth = 16'(1 + {$random(seed)} % 6);
    init(meth, 1'b0);
    wf(4);
    `CHK(hd(), 40'h81_000b_0000)
    `CHK(`EQ.fr[9], 8'h05)
    for (int i = 10; i < 18; i++) `CHK(`EQ.fr[i], 8'h00)
    ws(3'h2);
    `CHK(inq, int'(meth[0]))
    bus(1'b1, 9'h000, 32'h2);
    wf(5);
    `CHK(hd(), 40'h02_0002_0000)
    ws(3'h3);
    `CHK(net_enable_out, 1'b1)
    `CHK(sts, 1)
    repeat (30) @(posedge mclk_in);
    bus(1'b0, 9'h008, 32'h0);
    `CHK(rd[12], 1'b1)
    `EQ.put('{8'h00, 8'h02, 8'h80, 8'h5a, 8'h00, 8'h00}, 1'b0);
    repeat (40) @(posedge mclk_in);
    `CHK(`EQ.frames, 5)
    bus(1'b1, 9'h000, 32'h8);
    ws(3'h4);
    bus(1'b0, 9'h00c, 32'h0);
    `CHK(rd[15:0], 16'h03ec)
    `CHK(net_enable_out, 1'b0)
    mute <= 1'b1;
    bus(1'b1, 9'h01c, 32'h1);
    for (int i = 0; i < 18; i++)
      bus(1'b1, 9'h100 + 9'(4 * i), 32'ha0 + 32'(i));
    bus(1'b1, 9'h000, 32'h1);
    ws(3'h5);
    `CHK(rd[11:8], 4'h3)
    `CHK(hd(), 40'h00_0015_0201)
    `CHK({`EQ.fr[9], `EQ.fr[10], `EQ.fr[27]}, 24'h01_a0_b1)
    n0 = `EQ.frames;
    init(16'h0001, 1'b0);
    wf(n0 + 1);
    `CHK({`EQ.fr[3], `EQ.fr[7], `EQ.fr[8]}, 24'h81_0101)
    conclude();
  end
endmodule // test_adapter_init_command_handler
